// ==== shared/csps_defs.svh ====
/*
 * Constants of the colour sensor parameter store: word counts,
 * configuration indices, accepted ranges and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CSPS_DEFS_SVH
`define CSPS_DEFS_SVH
`define CSPS_CFG_WORDS 8'h11
`define CSPS_TEACH_WORDS 8'hF8
`define CSPS_RES_WORDS 8'h0E
`define CSPS_SPARE_COL 3'h7
`define CSPS_CAPTURE_CONDITION_FLAG_IX 4'h9
// configuration word indices, in transfer order
`define CSPS_IX_INTENSITY 5'h00
`define CSPS_IX_DRIVE 5'h01
`define CSPS_IX_AVERAGING_DEPTH 5'h02
`define CSPS_IX_METHOD 5'h03
`define CSPS_IX_HOLD 5'h04
`define CSPS_IX_THRESH 5'h05
`define CSPS_IX_COUNT 5'h06
`define CSPS_IX_OUTFN 5'h07
`define CSPS_IX_CAPTURE 5'h08
`define CSPS_IX_LEARN 5'h09
`define CSPS_IX_SPACE 5'h0A
`define CSPS_IX_WIN_LO 5'h0B
`define CSPS_IX_WIN_HI 5'h0C
`define CSPS_IX_CLUSTER 5'h0D
`define CSPS_IX_LIGHT 5'h0E
`define CSPS_IX_GAIN 5'h0F
`define CSPS_IX_INTEG 5'h10
// accepted upper bounds
`define CSPS_INTENSITY_MAX 16'h03E8
`define CSPS_ONE 16'h0001
`define CSPS_METHOD_MAX 16'h0004
`define CSPS_HOLD_MAX 16'h0064
`define CSPS_LEVEL_MAX 16'h0FFF
`define CSPS_COUNT_MAX 16'h001F
`define CSPS_OUTFN_MAX 16'h0002
`define CSPS_CAPTURE_MAX 16'h0006
`define CSPS_MODE3_MAX 16'h0003
`define CSPS_GAIN_MAX 16'h0008
`define CSPS_INTEG_MAX 16'h00FA
// reset values
`define CSPS_RST_INTENSITY 16'h01F4
`define CSPS_RST_HOLD 16'h0064
`define CSPS_RST_OUTFN 16'h0001
`define CSPS_RST_WIN_HI 16'h0FFF
`endif

// ==== shared/csps_pkg.sv ====
/*
 * Types of the colour sensor parameter store: transfer kinds,
 * mode encodings and the configuration and result carriers.
 * Assumes nothing beyond the shared defines header.
 */
package csps_pkg;
    typedef enum logic [1:0] {
        CSPS_PARAMS = 2'h0,
        CSPS_TEACH = 2'h1,
        CSPS_RESULTS = 2'h2
    } csps_kind_type;
    typedef enum logic [15:0] {
        ALWAYS_SAMPLE = 16'h0000, AUTONOMOUS_CAPTURE = 16'h0001,
        EXTERNAL_CAPTURE_A = 16'h0002, EXTERNAL_CAPTURE_B = 16'h0003,
        EXTERNAL_CAPTURE_C = 16'h0004, TRANSITION_CAPTURE = 16'h0005,
        PARAMETER_CAPTURE = 16'h0006
    } csps_capture_type;
    typedef enum logic [15:0] {
        FIRST_MATCH = 16'h0000, CLOSEST_MATCH = 16'h0001,
        MINIMUM_DISTANCE_MATCH = 16'h0002, FIVE_CHANNEL_METHOD = 16'h0003,
        PER_CHANNEL_THRESHOLD_METHOD = 16'h0004
    } csps_method_type;
    typedef enum logic [15:0] {
        ONE_HOT_HIGH = 16'h0000, BINARY_CODE = 16'h0001,
        ONE_HOT_LOW = 16'h0002
    } csps_outfn_type;
    typedef struct packed {
        logic [15:0] emitter_intensity, emitter_drive_select;
        logic [15:0] averaging_depth, match_method, failure_hold_time;
        logic [15:0] intensity_threshold, active_colour_count;
        logic [15:0] output_function, capture_mode, external_learn_mode;
        logic [15:0] colour_space_method, adaptive_window_low;
        logic [15:0] adaptive_window_high, clustering_enable;
        logic [15:0] light_source_control, receiver_amplification;
        logic [15:0] integration_length;
    } csps_cfg_type;
    typedef struct packed {
        logic [15:0] calibrated_red, calibrated_green, calibrated_blue;
        logic [15:0] chroma_first, chroma_second, luminance_value;
        logic [15:0] match_distance, matched_colour, matched_cluster;
        logic [15:0] capture_condition_flag, internal_heat_reading;
        logic [15:0] uncorrected_red, uncorrected_green, uncorrected_blue;
    } csps_result_type;
endpackage

// ==== hw/csps_cfg_check.sv ====
/*
 * Range and encoding check for one configuration word.
 * Assumes the index is one of the seventeen configuration slots.
 */
`timescale 1ns/1ns
`include "csps_defs.svh"
module csps_cfg_check (
    input wire logic [4:0] i_index,
    input wire logic [15:0] i_word,
    output logic o_ok
);
    // exactly one bit set: 1, 2, 4 ... 32768
    function automatic logic is_pow2(input logic [15:0] w);
        is_pow2 = (w != 16'h0000) && ((w & (w - 16'h0001)) == 16'h0000);
    endfunction

    // undefined codes are refused so the stored word stays legal
    always_comb begin
        if (i_index == `CSPS_IX_INTENSITY) o_ok = i_word <= `CSPS_INTENSITY_MAX;
        else if (i_index == `CSPS_IX_DRIVE) o_ok = i_word <= `CSPS_ONE;
        else if (i_index == `CSPS_IX_AVERAGING_DEPTH) o_ok = is_pow2(i_word);
        else if (i_index == `CSPS_IX_METHOD) o_ok = i_word <= `CSPS_METHOD_MAX;
        else if (i_index == `CSPS_IX_HOLD) o_ok = i_word <= `CSPS_HOLD_MAX;
        else if (i_index == `CSPS_IX_THRESH) o_ok = i_word <= `CSPS_LEVEL_MAX;
        else if (i_index == `CSPS_IX_COUNT)
            o_ok = (i_word >= `CSPS_ONE) && (i_word <= `CSPS_COUNT_MAX);
        else if (i_index == `CSPS_IX_OUTFN) o_ok = i_word <= `CSPS_OUTFN_MAX;
        else if (i_index == `CSPS_IX_CAPTURE) o_ok = i_word <= `CSPS_CAPTURE_MAX;
        else if (i_index == `CSPS_IX_LEARN) o_ok = i_word <= `CSPS_MODE3_MAX;
        else if (i_index == `CSPS_IX_SPACE) o_ok = i_word <= `CSPS_MODE3_MAX;
        else if (i_index == `CSPS_IX_WIN_LO) o_ok = i_word <= `CSPS_LEVEL_MAX;
        else if (i_index == `CSPS_IX_WIN_HI) o_ok = i_word <= `CSPS_LEVEL_MAX;
        else if (i_index == `CSPS_IX_CLUSTER) o_ok = i_word <= `CSPS_ONE;
        else if (i_index == `CSPS_IX_LIGHT) o_ok = i_word <= `CSPS_MODE3_MAX;
        else if (i_index == `CSPS_IX_GAIN)
            o_ok = (i_word >= `CSPS_ONE) && (i_word <= `CSPS_GAIN_MAX);
        else if (i_index == `CSPS_IX_INTEG)
            o_ok = (i_word >= `CSPS_ONE) && (i_word <= `CSPS_INTEG_MAX);
        else o_ok = 1'b0;
    end
endmodule

// ==== hw/csps_teach_mem.sv ====
/*
 * Teach table storage: thirty-one vectors of eight words.
 * Assumes one write port and a combinational read of the same index.
 */
`timescale 1ns/1ns
module csps_teach_mem #(
    parameter int DEPTH = 248
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [DEPTH];

    // no reset: contents are data, loaded by the host before use
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_addr];
endmodule

// ==== hw/csps_top.sv ====
/*
 * Parameter and result store of a colour sensor, reached as ordered
 * streams of 16-bit words, low byte first, from the frame handler.
 * Assumes the frame handler and measurement core share i_clk.
 */
// Notes on behaviour
// - each word travels as two bytes
// - configuration words move strictly in listed order
// - emitter intensity accepts 0 to 1000
// - drive mode: fixed 0, adaptive 1
// - averaging depth: powers of two to 32768
// - match method encoded 0 through 4
// - failure hold time word in milliseconds
// - intensity threshold accepts 0 to 4095
// - active colour count accepts 1 to 31
// - output function encoded 0 through 2
// - capture mode encoded 0 through 6
// - external learn mode encoded 0 through 3
// - colour space method encoded 0 through 3
// - adaptive window bounds each 0 to 4095
// - clustering enable: 0 off, 1 on
// - light source control encoded 0 through 3
// - gain steps 1 to 8, 0 undefined
// - integration length accepts 1 to 250
// - teach table: 31 vectors, one block
// - vector: five columns, cluster, hold, zero spare
// - result record leaves in fixed order
// - trigger flag reads 1 when capture configured
// - temperature word passes raw device units
`timescale 1ns/1ns
`include "csps_defs.svh"
module csps_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_xfer_start,
    input wire logic i_xfer_write,
    input csps_pkg::csps_kind_type i_xfer_kind,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_byte,
    input wire logic i_rd_req,
    input csps_pkg::csps_result_type i_result,
    output csps_pkg::csps_cfg_type o_cfg,
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte,
    output logic o_busy,
    output logic o_done,
    output logic o_reject
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } csps_state_type;

    csps_state_type state_reg;
    csps_pkg::csps_kind_type kind_reg;
    logic [7:0] ix_reg;
    logic hi_phase_reg;
    logic [7:0] lo_byte_reg;
    logic [0:16][15:0] cfg_reg;
    logic [0:13][15:0] snap_reg;
    logic o_rd_valid_reg;
    logic [7:0] o_rd_byte_reg;
    logic o_busy_reg;
    logic o_done_reg;
    logic o_reject_reg;
    logic [15:0] wr_word;
    logic wr_commit;
    logic rd_take;
    logic last_word;
    logic cfg_ok;
    logic tm_we;
    logic [15:0] tm_wdata;
    logic [15:0] tm_rdata;
    logic [15:0] rd_word;
    logic spare_slot;
    logic start_ok;

    // words in one block of each kind
    function automatic logic [7:0] words_of(input csps_pkg::csps_kind_type k);
        if (k == csps_pkg::CSPS_PARAMS) words_of = `CSPS_CFG_WORDS;
        else if (k == csps_pkg::CSPS_TEACH) words_of = `CSPS_TEACH_WORDS;
        else words_of = `CSPS_RES_WORDS;
    endfunction

    // a start is legal only for a known kind; results are read-only
    assign start_ok = (i_xfer_kind == csps_pkg::CSPS_PARAMS)
        || (i_xfer_kind == csps_pkg::CSPS_TEACH)
        || ((i_xfer_kind == csps_pkg::CSPS_RESULTS) && !i_xfer_write);

    // a word completes on its second byte, low byte first
    assign wr_word = {i_wr_byte, lo_byte_reg};
    assign wr_commit = (state_reg == ST_WRITE) && i_wr_valid && hi_phase_reg;
    assign rd_take = (state_reg == ST_READ) && i_rd_req;
    assign last_word = ix_reg == (words_of(kind_reg) - 8'h01);
    assign spare_slot = ix_reg[2:0] == `CSPS_SPARE_COL;

    csps_cfg_check u_check (
        .i_index(ix_reg[4:0]),
        .i_word(wr_word),
        .o_ok(cfg_ok)
    );

    // spare column is forced to zero whatever the host sends
    assign tm_we = wr_commit && (kind_reg == csps_pkg::CSPS_TEACH);
    assign tm_wdata = spare_slot ? 16'h0000 : wr_word;

    csps_teach_mem #(
        .DEPTH(248)
    ) u_teach (
        .i_clk(i_clk),
        .i_we(tm_we),
        .i_addr(ix_reg),
        .i_wdata(tm_wdata),
        .o_rdata(tm_rdata)
    );

    // word presented for reading at the current position
    always_comb begin
        rd_word = 16'h0000;
        if (kind_reg == csps_pkg::CSPS_PARAMS) begin
            rd_word = cfg_reg[ix_reg[4:0]];
        end else if (kind_reg == csps_pkg::CSPS_TEACH) begin
            rd_word = spare_slot ? 16'h0000 : tm_rdata;
        end else begin
            rd_word = snap_reg[ix_reg[3:0]];
        end
    end

    // transfer sequencing: one block per start, index walks upward
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            kind_reg <= csps_pkg::CSPS_PARAMS;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (i_xfer_start && start_ok) begin
                        kind_reg <= i_xfer_kind;
                        state_reg <= i_xfer_write ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (wr_commit && last_word) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (rd_take && hi_phase_reg && last_word) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // position within the block and byte phase within the word
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ix_reg <= 8'h00;
            hi_phase_reg <= 1'b0;
            lo_byte_reg <= 8'h00;
        end else if (state_reg == ST_IDLE) begin
            ix_reg <= 8'h00;
            hi_phase_reg <= 1'b0;
        end else if ((state_reg == ST_WRITE) && i_wr_valid) begin
            if (!hi_phase_reg) begin
                lo_byte_reg <= i_wr_byte;
            end else begin
                ix_reg <= ix_reg + 8'h01;
            end
            hi_phase_reg <= !hi_phase_reg;
        end else if (rd_take) begin
            if (hi_phase_reg) begin
                ix_reg <= ix_reg + 8'h01;
            end
            hi_phase_reg <= !hi_phase_reg;
        end
    end

    // configuration words; an illegal value leaves the old one in place
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_reg <= '0;
            cfg_reg[`CSPS_IX_INTENSITY] <= `CSPS_RST_INTENSITY;
            cfg_reg[`CSPS_IX_AVERAGING_DEPTH] <= `CSPS_ONE;
            cfg_reg[`CSPS_IX_HOLD] <= `CSPS_RST_HOLD;
            cfg_reg[`CSPS_IX_COUNT] <= `CSPS_ONE;
            cfg_reg[`CSPS_IX_OUTFN] <= `CSPS_RST_OUTFN;
            cfg_reg[`CSPS_IX_WIN_HI] <= `CSPS_RST_WIN_HI;
            cfg_reg[`CSPS_IX_GAIN] <= `CSPS_ONE;
            cfg_reg[`CSPS_IX_INTEG] <= `CSPS_ONE;
        end else if (wr_commit && (kind_reg == csps_pkg::CSPS_PARAMS) && cfg_ok) begin
            cfg_reg[ix_reg[4:0]] <= wr_word;
        end
    end

    // record is frozen at the start of a read so all words belong together
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            snap_reg <= '0;
        end else if ((state_reg == ST_IDLE) && i_xfer_start && start_ok
            && (i_xfer_kind == csps_pkg::CSPS_RESULTS)) begin
            snap_reg <= i_result;
            snap_reg[`CSPS_CAPTURE_CONDITION_FLAG_IX] <= {15'h0000, (cfg_reg[`CSPS_IX_CAPTURE]
                != csps_pkg::ALWAYS_SAMPLE)};
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_valid_reg <= 1'b0;
            o_rd_byte_reg <= 8'h00;
        end else begin
            o_rd_valid_reg <= rd_take;
            if (rd_take) begin
                o_rd_byte_reg <= hi_phase_reg ? rd_word[15:8] : rd_word[7:0];
            end
        end
    end

    // status: busy level, done pulse, sticky reject cleared by an accepted start
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_busy_reg <= 1'b0;
            o_done_reg <= 1'b0;
            o_reject_reg <= 1'b0;
        end else begin
            o_busy_reg <= (state_reg == ST_IDLE) ? (i_xfer_start && start_ok)
                : !((wr_commit || (rd_take && hi_phase_reg)) && last_word);
            o_done_reg <= (wr_commit || (rd_take && hi_phase_reg)) && last_word;
            if ((wr_commit && (kind_reg == csps_pkg::CSPS_PARAMS) && !cfg_ok)
                || ((state_reg == ST_IDLE) && i_xfer_start && !start_ok)) begin
                o_reject_reg <= 1'b1;
            end else if ((state_reg == ST_IDLE) && i_xfer_start) begin
                o_reject_reg <= 1'b0;
            end
        end
    end

    assign o_cfg = csps_pkg::csps_cfg_type'(cfg_reg);
    assign o_rd_valid = o_rd_valid_reg;
    assign o_rd_byte = o_rd_byte_reg;
    assign o_busy = o_busy_reg;
    assign o_done = o_done_reg;
    assign o_reject = o_reject_reg;

    // stored configuration never leaves its legal set
    a_intensity_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_INTENSITY] <= `CSPS_INTENSITY_MAX)
        else $error("intensity word above 1000");
    a_averaging_depth_pow2: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        $onehot(cfg_reg[`CSPS_IX_AVERAGING_DEPTH]))
        else $error("averaging depth not a power of two");
    a_count_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (cfg_reg[`CSPS_IX_COUNT] >= `CSPS_ONE)
        && (cfg_reg[`CSPS_IX_COUNT] <= `CSPS_COUNT_MAX))
        else $error("colour count outside 1 to 31");
    a_gain_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (cfg_reg[`CSPS_IX_GAIN] != 16'h0000)
        && (cfg_reg[`CSPS_IX_GAIN] <= `CSPS_GAIN_MAX))
        else $error("gain step outside 1 to 8");
    a_reject_keeps_word: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_commit && (kind_reg == csps_pkg::CSPS_PARAMS) && !cfg_ok)
        |=> $stable(cfg_reg) && o_reject)
        else $error("refused word changed the store");
    a_spare_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (rd_take && (kind_reg == csps_pkg::CSPS_TEACH) && spare_slot)
        |=> o_rd_valid && (o_rd_byte == 8'h00))
        else $error("spare teach word not zero");
    a_block_end: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_commit && (kind_reg == csps_pkg::CSPS_PARAMS) && last_word)
        |-> (ix_reg == 8'h10) ##1 (o_done && (state_reg == ST_IDLE)))
        else $error("parameter block did not end after word 17");
    a_capture_condition_flag_flag: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ((state_reg == ST_IDLE) && i_xfer_start && !i_xfer_write
        && (i_xfer_kind == csps_pkg::CSPS_RESULTS)) |=>
        (snap_reg[`CSPS_CAPTURE_CONDITION_FLAG_IX] == {15'h0000,
        ($past(cfg_reg[`CSPS_IX_CAPTURE]) != 16'h0000)}))
        else $error("trigger flag does not follow capture mode");
    a_read_answer: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        rd_take |=> o_rd_valid)
        else $error("read byte not answered in one cycle");
    a_no_answer: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !rd_take |=> !o_rd_valid)
        else $error("read answer without a request");

    // block framing: busy follows a start, done is one cycle with busy low
    a_start_busy: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ((state_reg == ST_IDLE) && i_xfer_start && start_ok) |=> (o_busy && !o_done))
        else $error("accepted start did not raise busy");
    a_done_pulse: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        o_done |-> !o_busy ##1 !o_done)
        else $error("done longer than one cycle or with busy");

    // the remaining stored words, except method, learn mode, colour space and clustering, stay inside their accepted sets
    a_drive_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_DRIVE] <= `CSPS_ONE)
        else $error("drive mode word above 1");
    a_hold_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_HOLD] <= `CSPS_HOLD_MAX)
        else $error("failure hold time above 100");
    a_thresh_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_THRESH] <= `CSPS_LEVEL_MAX)
        else $error("intensity threshold above 4095");
    a_outfn_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_OUTFN] <= `CSPS_OUTFN_MAX)
        else $error("output function code above 2");
    a_capture_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_CAPTURE] <= `CSPS_CAPTURE_MAX)
        else $error("capture mode code above 6");
    a_window_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (cfg_reg[`CSPS_IX_WIN_LO] <= `CSPS_LEVEL_MAX)
        && (cfg_reg[`CSPS_IX_WIN_HI] <= `CSPS_LEVEL_MAX))
        else $error("adaptive window bound above 4095");
    a_light_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        cfg_reg[`CSPS_IX_LIGHT] <= `CSPS_MODE3_MAX)
        else $error("light source code above 3");
    a_integ_range: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (cfg_reg[`CSPS_IX_INTEG] != 16'h0000)
        && (cfg_reg[`CSPS_IX_INTEG] <= `CSPS_INTEG_MAX))
        else $error("integration length outside 1 to 250");
endmodule

// ==== tb/csps_host.sv ====
/*
 * Host side model: drives word blocks over the byte port and gathers answers.
 * Assumes the store answers reads one cycle after each request.
 */
`timescale 1ns/1ns
module csps_host (
    input wire logic i_clk,
    input wire logic i_done,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_byte,
    output logic o_start,
    output logic o_write,
    output csps_pkg::csps_kind_type o_kind,
    output logic o_wr_valid,
    output logic [7:0] o_wr_byte,
    output logic o_rd_req
);
    logic [7:0] rx_q[$];
    int n_done;
    // idle levels from time zero
    initial begin
        o_start = 1'b0;
        o_write = 1'b0;
        o_kind = csps_pkg::CSPS_PARAMS;
        o_wr_valid = 1'b0;
        o_wr_byte = 8'h00;
        o_rd_req = 1'b0;
        n_done = 0;
    end
    // answers are flop outputs, so the pre-edge value is the settled one
    always @(posedge i_clk) begin
        if (i_rd_valid === 1'b1) rx_q.push_back(i_rd_byte);
        if (i_done === 1'b1) n_done++;
    end
    task automatic begin_block(input logic wr, input csps_pkg::csps_kind_type k);
        @(posedge i_clk);
        o_start <= 1'b1;
        o_write <= wr;
        o_kind <= k;
        @(posedge i_clk);
        o_start <= 1'b0;
    endtask
    // exactly one done pulse must follow each block
    task automatic settle(input int d, output bit ok);
        repeat (8) @(posedge i_clk);
        ok = (n_done == d + 1);
    endtask
    task automatic wr_block(input csps_pkg::csps_kind_type k, input logic [15:0] w[$],
                            output bit ok);
        int d;
        d = n_done;
        begin_block(1'b1, k);
        // valid stays high across words so no edge sees two assignments
        foreach (w[i]) begin
            o_wr_valid <= 1'b1;
            o_wr_byte <= w[i][7:0];
            @(posedge i_clk);
            o_wr_byte <= w[i][15:8];
            @(posedge i_clk);
        end
        o_wr_valid <= 1'b0;
        o_wr_byte <= 8'hA5;
        settle(d, ok);
    endtask
    task automatic rd_block(input csps_pkg::csps_kind_type k, input int n,
                            output logic [15:0] w[$], output bit ok);
        int d;
        d = n_done;
        rx_q.delete();
        w.delete();
        begin_block(1'b0, k);
        o_rd_req <= 1'b1;
        repeat (2 * n) @(posedge i_clk);
        o_rd_req <= 1'b0;
        settle(d, ok);
        ok = ok && (rx_q.size() == 2 * n);
        for (int i = 0; i < n; i++) begin
            w.push_back({rx_q[2 * i + 1], rx_q[2 * i]});
        end
    endtask
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the parameter store: config, teach and result blocks.
 * Assumes the host model in csps_host and one 100 MHz clock.
 */
`timescale 1ns/1ns
module tb;
    logic i_clk;
    logic i_sys_rst;
    logic start, wr, wr_valid, rd_req, rd_valid, busy, done, reject;
    logic [7:0] wr_byte, rd_byte;
    csps_pkg::csps_kind_type kind;
    csps_pkg::csps_result_type res;
    csps_pkg::csps_cfg_type cfg;
    int n_fail, total_checks, cyc;
    logic [15:0] q[$], r[$];
    bit ok;
    localparam logic [15:0] RST_V [17] = '{16'h01F4, 16'h0000, 16'h0001, 16'h0000,
        16'h0064, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0FFF, 16'h0000, 16'h0000, 16'h0001, 16'h0001};
    localparam logic [15:0] MAX_V [17] = '{16'h03E8, 16'h0001, 16'h8000, 16'h0004,
        16'h0064, 16'h0FFF, 16'h001F, 16'h0002, 16'h0006, 16'h0003, 16'h0003,
        16'h0FFF, 16'h0FFF, 16'h0001, 16'h0003, 16'h0008, 16'h00FA};
    localparam logic [15:0] BAD_V [17] = '{16'h03E9, 16'h0002, 16'h0003, 16'h0005,
        16'h0065, 16'h1000, 16'h0000, 16'h0003, 16'h0007, 16'h0004, 16'h0004,
        16'h1000, 16'h1000, 16'h0002, 16'h0004, 16'h0000, 16'h00FB};
    localparam logic [15:0] MIN_V [17] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000,
        16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001};
    csps_top u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_xfer_start(start),
        .i_xfer_write(wr), .i_xfer_kind(kind), .i_wr_valid(wr_valid),
        .i_wr_byte(wr_byte), .i_rd_req(rd_req), .i_result(res), .o_cfg(cfg),
        .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_busy(busy), .o_done(done),
        .o_reject(reject));
    csps_host u_host (.i_clk(i_clk), .i_done(done), .i_rd_valid(rd_valid),
        .i_rd_byte(rd_byte), .o_start(start), .o_write(wr), .o_kind(kind),
        .o_wr_valid(wr_valid), .o_wr_byte(wr_byte), .o_rd_req(rd_req));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // hang guard: the whole run needs under two thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    function automatic logic [15:0] cw(input int i);
        return cfg[271 - 16 * i -: 16];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic load(input logic [15:0] v [17]);
        q.delete();
        foreach (v[i]) q.push_back(v[i]);
        u_host.wr_block(csps_pkg::CSPS_PARAMS, q, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask
    task automatic t_cfg();
        foreach (RST_V[i]) chk(cw(i), RST_V[i]);
        load(MAX_V);
        chk({15'h0000, reject}, 16'h0000);
        foreach (MAX_V[i]) chk(cw(i), MAX_V[i]);
        u_host.rd_block(csps_pkg::CSPS_PARAMS, 17, r, ok);
        chk({15'h0000, ok}, 16'h0001);
        foreach (MAX_V[i]) chk(r[i], MAX_V[i]);
        // every word outside its accepted set: all refused, old values kept
        load(BAD_V);
        chk({15'h0000, reject}, 16'h0001);
        foreach (MAX_V[i]) chk(cw(i), MAX_V[i]);
        load(MIN_V);
        chk({15'h0000, reject}, 16'h0000);
        foreach (MIN_V[i]) chk(cw(i), MIN_V[i]);
        $display("test cfg done");
    endtask
    task automatic t_teach();
        q.delete();
        for (int i = 0; i < 248; i++) begin
            // spare word of each vector goes out as zero
            q.push_back((i % 8 == 7) ? 16'h0000 : {i[7:0] ^ 8'h5A, i[7:0]});
        end
        u_host.wr_block(csps_pkg::CSPS_TEACH, q, ok);
        chk({15'h0000, ok}, 16'h0001);
        u_host.rd_block(csps_pkg::CSPS_TEACH, 248, r, ok);
        chk({15'h0000, ok}, 16'h0001);
        foreach (q[i]) chk(r[i], q[i]);
        $display("test teach done");
    endtask
    task automatic t_result(input logic [15:0] flag);
        @(posedge i_clk);
        for (int i = 0; i < 14; i++) res[223 - 16 * i -: 16] <= 16'h2200 + i[15:0] + flag;
        u_host.rd_block(csps_pkg::CSPS_RESULTS, 14, r, ok);
        chk({15'h0000, ok}, 16'h0001);
        for (int i = 0; i < 14; i++) begin
            chk(r[i], (i == 9) ? flag : 16'h2200 + i[15:0] + flag);
        end
        $display("test result done");
    endtask
    task automatic t_illegal();
        u_host.begin_block(1'b1, csps_pkg::CSPS_RESULTS);
        repeat (3) @(posedge i_clk);
        chk({15'h0000, reject}, 16'h0001);
        chk({15'h0000, busy}, 16'h0000);
        // a legal block clears the flag, so the unknown kind must set it again
        u_host.rd_block(csps_pkg::CSPS_PARAMS, 17, r, ok);
        chk({15'h0000, reject}, 16'h0000);
        u_host.begin_block(1'b0, csps_pkg::csps_kind_type'(2'h3));
        repeat (3) @(posedge i_clk);
        chk({15'h0000, reject}, 16'h0001);
        chk({15'h0000, busy}, 16'h0000);
        $display("test illegal start done");
    endtask
    initial begin
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        res = '0;
        i_sys_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_cfg();
        t_teach();
        t_result(16'h0000);
        load(MAX_V);
        t_result(16'h0001);
        t_illegal();
        close_out();
    end
endmodule
